// ### dv/acmr_fifo_model.sv
`default_nettype none
module acmr_fifo_model #(
    parameter int NF = 6
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // dma requests and fifo levels
    input  wire logic [NF-1:0] fill_req,
    input  wire logic [NF-1:0] drain_req,
    input  wire logic [3:0]    dly,
    output var  logic [NF-1:0] full,
    output var  logic [NF-1:0] empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt [NF];
    // one word moved per request cycle; a large dly stalls the far side
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NF; i++) begin
            cnt[i] <= (aresetn && (fill_req[i] || drain_req[i])) ? cnt[i] + 4'h1 : 4'h0;
            full[i] <= aresetn && fill_req[i] && cnt[i] == dly;
            empty[i] <= aresetn && drain_req[i] && cnt[i] == dly;
        end
    end
endmodule
`default_nettype wire

// ### dv/test_adc_channel_mux_request_logic.sv
`default_nettype none
module test_adc_channel_mux_request_logic;
    import acmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NF = 6;
    logic          aclk, aresetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
    logic          comp_hi, comp_lo, cei, irq, sv, ma_msb, ma_mid, ma_lsb;
    logic [7:0]    awa, ara;
    logic [31:0]   wd, rdat, rd, seed, miscompares, check_count, cyc;
    logic [1:0]    br, rr, ss, resp;
    logic [3:0]    dly;
    logic [5:0]    sel;
    logic [11:0]   res;
    logic [NF-1:0] ev [8];
    logic [NF-1:0] fq, dq, full, empty, fi;
    logic [2:0]    pm;
    int            q, b, n;
    acmr_top #(.NF(NF)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .ev_noncoherency(ev[0]), .ev_trig_overrun(ev[1]), .ev_pause(ev[2]),
        .ev_end_of_queue(ev[3]), .ev_cmd_underflow(ev[4]), .ev_cmd_fill(ev[5]),
        .ev_result_overflow(ev[6]), .ev_result_drain(ev[7]),
        .cmd_fifo_full(full), .result_fifo_empty(empty), .fifo_irq(fi),
        .cmd_fill_dma_req(fq), .result_drain_dma_req(dq), .combined_err_irq(cei),
        .irq(irq), .input_select(sel), .input_select_valid(sv), .mux_addr_msb(ma_msb),
        .mux_addr_mid(ma_mid), .mux_addr_lsb(ma_lsb), .comp_hi(comp_hi), .comp_lo(comp_lo),
        .sum_sel(ss), .conv_result(res)
    );
    acmr_fifo_model #(.NF(NF)) far (
        .aclk(aclk), .aresetn(aresetn), .fill_req(fq), .drain_req(dq), .dly(dly),
        .full(full), .empty(empty)
    );
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 32'h0000_9c40) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count = check_count + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            ta = ta | awr;
            tw = tw | wrd;
        end while (!(ta && tw));
        while (!bv) @(posedge aclk);
        bry <= 1'b0;
        resp = br;
    endtask
    task automatic rd_(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        rry <= 1'b0;
        rd = rdat;
        resp = rr;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic ext(logic [7:0] c);
        return c inside {[8'h40:8'h5f], [8'he0:8'hf7]};
    endfunction
    function automatic logic ok(logic [7:0] c, logic m);
        if (!m) return c < 8'h2d;
        return (c < 8'h2d && !(c inside {[8'h08:8'h0b], [8'h10:8'h12]})) || ext(c);
    endfunction
    // thirteen digits weighted 2^12 down to 1, then offset, halved and clamped
    function automatic logic [11:0] cexp(int d);
        int s;
        s = (d * 8191 - 4095) / 2;
        return s < 0 ? 12'h000 : (s > 4095 ? 12'hfff : 12'(s));
    endfunction
    task automatic chan(input logic m, input logic [7:0] c);
        logic [5:0] px;
        px = (c[7] ? PIN_RST : PIN_WXYZ) + 6'(c[4:3]);
        wr(OFS_CHAN, {24'h00_0000, c});
        if (m && ext(c)) pm = c[2:0];
        rd_(OFS_CHAN);
        chk({ma_msb, ma_mid, ma_lsb}, pm);
        chk({rd[15], sv}, {2{ok(c, m)}});
        if (ok(c, m)) chk(sel, (m && ext(c)) ? px : c[5:0]);
    endtask
    initial begin
        {aresetn, awv, wv, bry, arv, rry, comp_hi, comp_lo} = '0;
        {awa, ara, wd, pm, cyc, miscompares, check_count} = '0;
        for (int i = 0; i < 8; i++) ev[i] = '0;
        dly = 4'h4;
        seed = 32'h0000_004a;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_(OFS_MASK);
        chk(rd, 0);
        chk({fi, fq, dq, cei, irq, sv}, 0);
        wr(8'hfc, 1);
        chk(resp, RESP_ERR);
        rd_(8'h02);
        chk(resp, RESP_ERR);
        wr(8'h21, 1);
        chk(resp, RESP_ERR);
        rd_(OFS_FCTL);
        chk(rd, 0);
        $display("test registers finished");
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, m);
            for (int c = 0; c < 256; c++) chan(m[0], 8'(c));
        end
        $display("test channels finished");
        for (int k = 0; k < 8; k++) begin
            q = xs() % NF;
            b = k < 6 ? k : k + 1;
            wr(8'(OFS_FCTL + 4 * q), 1 << b);
            ev[k][q] <= 1'b1;
            @(posedge aclk);
            ev[k] <= '0;
            tick(3);
            chk({fi, cei}, {NF'(1 << q), k == 1 || k == 4 || k == 6});
            wr(8'(OFS_FFLG + 4 * q), 1 << b);
            tick(3);
            chk({fi, cei}, 0);
            wr(8'(OFS_FCTL + 4 * q), 0);
        end
        for (int j = 0; j < 4; j++) begin
            b = j[0] ? 8 : 5;
            dly <= j[1] ? 4'h9 : 4'h4;
            q = xs() % NF;
            wr(8'(OFS_FCTL + 4 * q), 3 << b);
            ev[b == 8 ? 7 : 5][q] <= 1'b1;
            @(posedge aclk);
            ev[b == 8 ? 7 : 5] <= '0;
            tick(3);
            chk({fi, fq, dq}, b == 8 ? 1 << q : (1 << q) << NF);
            n = 0;
            while ((fq | dq) != 0 && n < 40) begin
                tick(1);
                n++;
            end
            rd_(8'(OFS_FFLG + 4 * q));
            chk({fq, dq, rd[b]}, 0);
            wr(8'(OFS_FCTL + 4 * q), 0);
        end
        $display("test requests finished");
        for (int j = 0; j < 3; j++) begin
            comp_hi <= j == 2;
            comp_lo <= j != 0;
            wr(OFS_CONV, 1);
            tick(3);
            chk(ss, j == 2 ? SUM_MINUS : (j == 1 ? SUM_ZERO : SUM_PLUS));
            rd_(OFS_CONV);
            chk(rd[0], 1);
            n = 0;
            while (rd[0] && n < 30) begin
                rd_(OFS_CONV);
                n++;
            end
            chk({rd[27:16], res}, {cexp(j), cexp(j)});
        end
        chk(irq, 0);
        wr(OFS_MASK, 1);
        tick(3);
        chk(irq, 1);
        wr(OFS_STAT, 1);
        tick(3);
        chk(irq, 0);
        $display("test conversion finished");
        wrap_up();
    end
endmodule
`default_nettype wire

// ### hdl/acmr_top.sv
// Function
// - plain mode codes 0-39 pick pins
// - codes 40-44 pick reference points
// - control bit enables external multiplexing
// - mux mode reserves codes 8-11, 16-18
// - code groups route to external mux inputs
// - address pins from low three code bits
// - address pins driven only in mux mode
// - queue interrupt when enable and flag
// - fill interrupt when enabled, select zero
// - drain interrupt when enabled, select zero
// - drain request, self clear when empty
// - fill request, self clear when full
// - combined error interrupt ORs all queues
// - thirteen stage passes per conversion
// - comparators pick summing term and digit
// - store thirteen digit pairs, then add
// - twelve-bit result, first element msb
`default_nettype none
module acmr_top
    import acmr_pkg::*;
#(
    parameter int NF = 6
) (
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // axi4-lite slave
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output var  logic            s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output var  logic            s_axi_wready,
    output var  logic [1:0]      s_axi_bresp,
    output var  logic            s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output var  logic            s_axi_arready,
    output var  logic [31:0]     s_axi_rdata,
    output var  logic [1:0]      s_axi_rresp,
    output var  logic            s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // queue events and levels
    input  wire logic [NF-1:0]   ev_noncoherency,
    input  wire logic [NF-1:0]   ev_trig_overrun,
    input  wire logic [NF-1:0]   ev_pause,
    input  wire logic [NF-1:0]   ev_end_of_queue,
    input  wire logic [NF-1:0]   ev_cmd_underflow,
    input  wire logic [NF-1:0]   ev_cmd_fill,
    input  wire logic [NF-1:0]   ev_result_overflow,
    input  wire logic [NF-1:0]   ev_result_drain,
    input  wire logic [NF-1:0]   cmd_fifo_full,
    input  wire logic [NF-1:0]   result_fifo_empty,
    // requests
    output var  logic [NF-1:0]   fifo_irq,
    output var  logic [NF-1:0]   cmd_fill_dma_req,
    output var  logic [NF-1:0]   result_drain_dma_req,
    output var  logic            combined_err_irq,
    output var  logic            irq,
    // channel selection
    output var  logic [5:0]      input_select,
    output var  logic            input_select_valid,
    output var  logic            mux_addr_msb,
    output var  logic            mux_addr_mid,
    output var  logic            mux_addr_lsb,
    // redundant_digit_stage
    input  wire logic            comp_hi,
    input  wire logic            comp_lo,
    output var  logic [1:0]      sum_sel,
    output var  logic [RES_W-1:0] conv_result
);

    function automatic logic [31:0] byte_mask(input logic [3:0] strb);
        byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // {valid, external, pin}
    function automatic logic [7:0] chan_decode(input logic [7:0] c, input logic emux);
        logic [5:0] pin;
        logic       ok;
        logic       ext;
        pin = c[5:0];
        ok  = c <= CH_REF_LAST;
        ext = 1'b0;
        if (emux) begin
            if (c[5:0] >= PIN_WXYZ && c[5:0] <= PIN_RSV_HI && c[7:6] == 2'b00
                && (c[4] == 1'b0 || c[3:0] <= PIN_RSV_HI[3:0]) && c[5:0] != 6'h0c
                && c[5:0] != 6'h0d && c[5:0] != 6'h0e && c[5:0] != 6'h0f)
                ok = 1'b0;
            if (c[7:5] == TAG_WXYZ) begin
                ok  = 1'b1;
                ext = 1'b1;
                pin = PIN_WXYZ + {4'h0, c[4:3]};
            end else if (c[7:5] == TAG_RST && c[4:3] != 2'b11) begin
                ok  = 1'b1;
                ext = 1'b1;
                pin = PIN_RST + {4'h0, c[4:3]};
            end
        end
        chan_decode = {ok, ext, pin};
    endfunction

    // ---------------- bus slave ----------------
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_full;
    logic        w_full;
    logic        do_wr;
    logic        wr_ok;
    logic [31:0] wm;

    assign do_wr = aw_full && w_full && !s_axi_bvalid;
    assign wm    = byte_mask(w_strb) & w_data;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_full       <= 1'b0;
            aw_addr       <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_full <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_full       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (do_wr) begin
            w_full <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        wr_ok = aw_addr <= OFS_MASK && aw_addr[1:0] == 2'b00;
        if (aw_addr[7:5] != 3'h0 && aw_addr[4:2] < NF[2:0] && aw_addr[1:0] == 2'b00
            && (aw_addr[7:5] == OFS_FCTL[7:5] || aw_addr[7:5] == OFS_FFLG[7:5]))
            wr_ok = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic        chan_go;
    logic        conv_go;
    logic [7:0]  chan_dec;
    logic        emux;
    assign chan_go  = do_wr && aw_addr == OFS_CHAN && w_strb[0];
    assign conv_go  = do_wr && aw_addr == OFS_CONV && w_strb[0] && w_data[0];
    assign chan_dec = chan_decode(w_data[7:0], emux);

    // ---------------- control and channel ----------------
    logic [7:0] chan_code;
    logic [1:0] gstat;
    logic [1:0] gmask;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            emux <= 1'b0;
        else if (do_wr && aw_addr == OFS_CTRL && w_strb[0])
            emux <= w_data[BIT_EMUX];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_code          <= 8'h00;
            input_select       <= 6'h00;
            input_select_valid <= 1'b0;
            mux_addr_msb       <= 1'b0;
            mux_addr_mid       <= 1'b0;
            mux_addr_lsb       <= 1'b0;
        end else if (chan_go) begin
            chan_code          <= w_data[7:0];
            input_select_valid <= chan_dec[7];
            if (chan_dec[7])
                input_select <= chan_dec[5:0];
            if (chan_dec[7] && chan_dec[6] && emux) begin
                mux_addr_msb <= w_data[2];
                mux_addr_mid <= w_data[1];
                mux_addr_lsb <= w_data[0];
            end
        end
    end

    // ---------------- per-queue flags ----------------
    logic [NF-1:0][FW-1:0] fifo_ctl;
    logic [NF-1:0][FW-1:0] fifo_flag;
    logic [NF-1:0][FW-1:0] set_v;
    logic [NF-1:0][FW-1:0] clr_v;

    always_comb begin
        for (int n = 0; n < NF; n++) begin
            set_v[n] = '0;
            set_v[n][BIT_NC]  = ev_noncoherency[n];
            set_v[n][BIT_TOR] = ev_trig_overrun[n];
            set_v[n][BIT_PAU] = ev_pause[n];
            set_v[n][BIT_EOQ] = ev_end_of_queue[n];
            set_v[n][BIT_CFU] = ev_cmd_underflow[n];
            set_v[n][BIT_CFF] = ev_cmd_fill[n];
            set_v[n][BIT_RFO] = ev_result_overflow[n];
            set_v[n][BIT_RFD] = ev_result_drain[n];
            clr_v[n] = '0;
            if (do_wr && wr_ok && aw_addr[7:5] == OFS_FFLG[7:5] && aw_addr[4:2] == n[2:0]) begin
                clr_v[n] = wm[FW-1:0] & FLAG_MASK;
                // dma mode owns these flags; software ones are dropped
                if (fifo_ctl[n][BIT_CFS])
                    clr_v[n][BIT_CFF] = 1'b0;
                if (fifo_ctl[n][BIT_RDS])
                    clr_v[n][BIT_RFD] = 1'b0;
            end
            if (fifo_ctl[n][BIT_CFF] && fifo_ctl[n][BIT_CFS] && cmd_fifo_full[n])
                clr_v[n][BIT_CFF] = 1'b1;
            if (fifo_ctl[n][BIT_RFD] && fifo_ctl[n][BIT_RDS] && result_fifo_empty[n])
                clr_v[n][BIT_RFD] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        for (int n = 0; n < NF; n++) begin
            if (!aresetn) begin
                fifo_ctl[n]  <= CTL_RESET;
                fifo_flag[n] <= '0;
            end else begin
                if (do_wr && wr_ok && aw_addr[7:5] == OFS_FCTL[7:5] && aw_addr[4:2] == n[2:0])
                    fifo_ctl[n] <= (fifo_ctl[n] & ~FW'(byte_mask(w_strb)))
                                   | wm[FW-1:0];
                // set beats clear
                fifo_flag[n] <= ((fifo_flag[n] & ~clr_v[n]) | set_v[n]) & FLAG_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_irq             <= '0;
            cmd_fill_dma_req     <= '0;
            result_drain_dma_req <= '0;
            combined_err_irq     <= 1'b0;
        end else begin
            combined_err_irq <= 1'b0;
            for (int n = 0; n < NF; n++) begin
                fifo_irq[n] <= |(fifo_ctl[n] & fifo_flag[n] & IE_MASK)
                    | (fifo_ctl[n][BIT_CFF] && !fifo_ctl[n][BIT_CFS]
                       && fifo_flag[n][BIT_CFF])
                    | (fifo_ctl[n][BIT_RFD] && !fifo_ctl[n][BIT_RDS]
                       && fifo_flag[n][BIT_RFD]);
                cmd_fill_dma_req[n] <= fifo_ctl[n][BIT_CFF] && fifo_ctl[n][BIT_CFS]
                                       && fifo_flag[n][BIT_CFF];
                result_drain_dma_req[n] <= fifo_ctl[n][BIT_RFD] && fifo_ctl[n][BIT_RDS]
                                           && fifo_flag[n][BIT_RFD];
                if (|(fifo_ctl[n] & fifo_flag[n] & ERR_MASK))
                    combined_err_irq <= 1'b1;
            end
        end
    end

    // ---------------- converter sequencing ----------------
    acmr_state_t state;
    logic [3:0]  pass_cnt;
    logic [1:0]  digits [NUM_DIGITS];
    logic [14:0] acc;
    logic [14:0] excess;

    always_comb begin
        acc = '0;
        for (int i = 0; i < NUM_DIGITS; i++)
            acc = 15'((acc << 1) + {14'h0, digits[i][1]} + {14'h0, digits[i][0]});
        // offset removes the signed-digit bias before halving
        excess = acc - 15'h0fff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= CV_IDLE;
            pass_cnt <= 4'h0;
            sum_sel  <= SUM_ZERO;
        end else begin
            case (state)
                CV_IDLE: begin
                    sum_sel <= SUM_ZERO;
                    if (conv_go)
                        state <= CV_SAMPLE;
                end
                CV_SAMPLE, CV_PASS: begin
                    digits[pass_cnt] <= {comp_hi, comp_lo};
                    sum_sel  <= comp_hi ? SUM_MINUS : (comp_lo ? SUM_ZERO : SUM_PLUS);
                    pass_cnt <= pass_cnt + 4'h1;
                    state    <= CV_PASS;
                    if (pass_cnt == 4'(NUM_DIGITS - 1))
                        state <= CV_ADD;
                end
                CV_ADD: begin
                    pass_cnt <= 4'h0;
                    sum_sel  <= SUM_ZERO;
                    state    <= CV_IDLE;
                end
                default: state <= CV_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            conv_result <= '0;
        else if (state == CV_ADD) begin
            if (acc < 15'h0fff)
                conv_result <= '0;
            else if (excess[14:1] > 14'h0fff)
                conv_result <= 12'hfff;
            else
                conv_result <= excess[12:1];
        end
    end

    // ---------------- global interrupt ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gstat <= 2'h0;
            gmask <= 2'h0;
            irq   <= 1'b0;
        end else begin
            if (do_wr && aw_addr == OFS_MASK && w_strb[0])
                gmask <= w_data[1:0];
            gstat <= (gstat & ~((do_wr && aw_addr == OFS_STAT) ? wm[1:0] : 2'h0))
                     | {chan_go && !chan_dec[7], state == CV_ADD};
            irq   <= |(gstat & gmask);
        end
    end

    // ---------------- read path ----------------
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            OFS_CTRL: rd_mux[0] = emux;
            OFS_CHAN: rd_mux = {16'h0000, input_select_valid, 1'b0, input_select, chan_code};
            OFS_CONV: rd_mux = {4'h0, conv_result, 15'h0000, state != CV_IDLE};
            OFS_STAT: rd_mux[1:0] = gstat;
            OFS_MASK: rd_mux[1:0] = gmask;
            default: begin
                rd_ok = 1'b0;
                if (s_axi_araddr[4:2] < NF[2:0] && s_axi_araddr[1:0] == 2'b00) begin
                    if (s_axi_araddr[7:5] == OFS_FCTL[7:5]) begin
                        rd_ok  = 1'b1;
                        rd_mux[FW-1:0] = fifo_ctl[s_axi_araddr[4:2]];
                    end else if (s_axi_araddr[7:5] == OFS_FFLG[7:5]) begin
                        rd_ok  = 1'b1;
                        rd_mux[FW-1:0] = fifo_flag[s_axi_araddr[4:2]];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? RESP_OK : RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- checks ----------------
    pass_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == CV_SAMPLE) |=> (state == CV_PASS)[*8] ##1 (state == CV_PASS)[*4]
        ##1 (state == CV_ADD)) else $error("conversion did not take 13 passes");
    mux_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (chan_go && emux && chan_dec[6]) |=>
        {mux_addr_msb, mux_addr_mid, mux_addr_lsb} == $past(w_data[2:0]))
        else $error("mux address not taken from channel code");
    mux_plain_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !emux |=> $stable({mux_addr_msb, mux_addr_mid, mux_addr_lsb}))
        else $error("mux address moved outside mux mode");
    resv_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (chan_go && !chan_dec[7]) |=> !input_select_valid && $stable(input_select))
        else $error("reserved channel selected an input");
    ref_mid_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (chan_go && w_data[7:0] == CH_REF_MID) |=> input_select_valid
        && input_select == CH_REF_MID[5:0]) else $error("mid reference not selected");
    queue_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |(fifo_ctl[0] & fifo_flag[0] & IE_MASK) |=> fifo_irq[0])
        else $error("queue interrupt missing");
    fill_dma_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fifo_ctl[0][BIT_CFF] && fifo_ctl[0][BIT_CFS] && fifo_flag[0][BIT_CFF]
        && cmd_fifo_full[0] && !ev_cmd_fill[0]) |=> cmd_fill_dma_req[0]
        ##1 !cmd_fill_dma_req[0]) else $error("fill request not retired when full");
    drain_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fifo_ctl[0][BIT_RFD] && fifo_ctl[0][BIT_RDS] && result_fifo_empty[0]
        && !ev_result_drain[0]) |=> !fifo_flag[0][BIT_RFD])
        else $error("drain flag not cleared when empty");
    err_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |(fifo_ctl[0] & fifo_flag[0] & ERR_MASK) |=> combined_err_irq)
        else $error("combined error missed queue 0");

endmodule
`default_nettype wire

// ### include/acmr_pkg.sv
`default_nettype none
package acmr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CHAN   = 8'h04;
    localparam logic [7:0] OFS_CONV   = 8'h08;
    localparam logic [7:0] OFS_STAT   = 8'h0c;
    localparam logic [7:0] OFS_MASK   = 8'h10;
    localparam logic [7:0] OFS_FCTL   = 8'h20;
    localparam logic [7:0] OFS_FFLG   = 8'h40;
    // converter_control_reg field
    localparam int BIT_EMUX = 0;
    // per-queue control / flag positions (flag sits under its enable)
    localparam int BIT_NC   = 0;
    localparam int BIT_TOR  = 1;
    localparam int BIT_PAU  = 2;
    localparam int BIT_EOQ  = 3;
    localparam int BIT_CFU  = 4;
    localparam int BIT_CFF  = 5;
    localparam int BIT_CFS  = 6;
    localparam int BIT_RFO  = 7;
    localparam int BIT_RFD  = 8;
    localparam int BIT_RDS  = 9;
    localparam int FW       = 10;
    localparam logic [9:0] FLAG_MASK = 10'h1bf;
    localparam logic [9:0] IE_MASK   = 10'h09f;
    localparam logic [9:0] ERR_MASK  = 10'h092;
    localparam logic [9:0] CTL_RESET = 10'h000;
    // global status bits
    localparam int ST_DONE = 0;
    localparam int ST_RESV = 1;
    // channel codes
    localparam logic [7:0] CH_REF_LAST = 8'h2c;
    localparam logic [7:0] CH_REF_MID  = 8'h2a;
    localparam logic [5:0] PIN_WXYZ    = 6'h08;
    localparam logic [5:0] PIN_RST     = 6'h10;
    localparam logic [5:0] PIN_RSV_HI  = 6'h12;
    localparam logic [2:0] TAG_WXYZ    = 3'h2;
    localparam logic [2:0] TAG_RST     = 3'h7;
    // converter
    localparam int NUM_DIGITS = 13;
    localparam int RES_W      = 12;
    localparam logic [1:0] SUM_ZERO  = 2'h0;
    localparam logic [1:0] SUM_MINUS = 2'h1;
    localparam logic [1:0] SUM_PLUS  = 2'h2;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;
    typedef enum logic [1:0] {CV_IDLE, CV_SAMPLE, CV_PASS, CV_ADD} acmr_state_t;
endpackage
`default_nettype wire
